// [hw/swire_master.sv]
// Frame engine of the single-wire push-pull master.
`timescale 1ns/1ps
module swire_master
(
  input  wire logic                    i_clk,         // Core clock.
  input  wire logic                    i_rst,         // Async reset.
  input  wire logic [15:0]             i_slot_div,    // Cycles per slot.
  input  wire logic                    i_receive_enable, // Pull capture.
  input  wire logic                    i_long_low_request, // Break pulse.
  input  wire swire_pkg::push_byte_t   i_push_byte,   // Byte to send.
  input  wire logic                    i_push_valid,  // Byte offered.
  output logic                         o_push_ready,  // Byte accepted.
  input  wire logic                    i_pull_in_pin, // Line readback.
  output logic                         o_push_out_pin, // Line drive.
  output swire_pkg::frame_result_t     o_result,      // Frame result.
  output logic                         o_result_valid, // Result held.
  input  wire logic                    i_result_ready, // Result taken.
  output logic                         o_busy         // Frame running.
);

  // -----------------------------------------------------------------
  // Pin synchroniser
  // -----------------------------------------------------------------
  logic pin_meta; // First stage, read only by the second.
  logic pin_sync; // Line level in the core domain.

  // The pull pin is asynchronous, so it passes two flip-flops.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end
    else
    begin
      pin_meta <= i_pull_in_pin;
      pin_sync <= pin_meta;
    end
  end

  // -----------------------------------------------------------------
  // Slot timer
  // -----------------------------------------------------------------
  logic [15:0] slot_cnt;  // Cycles left in the slot.
  logic        slot_tick; // Last cycle of a slot.
  logic        mid_tick;  // Middle of a slot, for sampling.

  // A zero divider would stall the engine, so it counts as one.
  assign slot_tick = (slot_cnt == 16'h0000);
  assign mid_tick  = (slot_cnt == (i_slot_div >> 1));

  // Free-running slot divider of the core clock.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      slot_cnt <= 16'h0000;
    else if (slot_tick)
      slot_cnt <= (i_slot_div == 16'h0000) ? 16'h0000 : i_slot_div - 16'h0001;
    else
      slot_cnt <= slot_cnt - 16'h0001;
  end

  // -----------------------------------------------------------------
  // Frame sequencer
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_SYNC, ST_PUSH, ST_PSYNC, ST_PULL, ST_LONG
  } state_t;

  state_t     state;     // Current frame phase.
  logic [4:0] slot_idx;  // Slot count inside the phase.
  logic [3:0] bit_idx;   // Bit count inside the phase.
  logic [7:0] shift_out; // Push bits, LSB first.
  logic [7:0] shift_in;  // Pull bits collected.
  logic       bit_error; // Readback mismatch seen.
  logic       first_half; // First slot of a biphase bit.
  logic       long_pend; // Long low waiting for a slot boundary.
  logic       hold_full; // Result buffer holds a word.

  // Biphase first slot is the inverse of the bit.
  function automatic logic biphase(input logic b, input logic first);
    biphase = first ? ~b : b;
  endfunction

  // A byte is accepted only when idle and the result buffer has room,
  // so a slow reader stalls the source instead of losing a frame.
  // Ready is registered, so it lags the engine by one cycle; the idle
  // branch below still gives a pending long low priority over a byte.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_push_ready <= 1'b0;
    else
      o_push_ready <= (state == ST_IDLE) & ~hold_full & ~long_pend;
  end

  // Latch a long low request until the long low phase begins.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      long_pend <= 1'b0;
    else if (i_long_low_request)
      long_pend <= 1'b1;
    else if (state == ST_LONG)
      long_pend <= 1'b0;
  end

  // Phase sequencing, one step per slot, all in hardware.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state      <= ST_IDLE;
      slot_idx   <= 5'h00;
      bit_idx    <= 4'h0;
      first_half <= 1'b1;
      shift_out  <= 8'h00;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          // Only a slot boundary may open a frame.
          if (slot_tick && long_pend)
          begin
            state    <= ST_LONG;
            slot_idx <= 5'h00;
          end
          else if (slot_tick && i_push_valid && o_push_ready)
          begin
            state     <= ST_START;
            slot_idx  <= 5'h00;
            // Data in bits 4..0, address in 7..5.
            shift_out <= {i_push_byte.addr, i_push_byte.data};
          end
        end
        ST_START:
          // Three low slots break the coding.
          if (slot_tick)
          begin
            if (slot_idx == 5'(swire_pkg::START_SLOTS - 1))
            begin
              state      <= ST_SYNC;
              first_half <= 1'b1;
            end
            slot_idx <= slot_idx + 5'h01;
          end
        ST_SYNC:
          // Push sync follows the start directly.
          if (slot_tick)
          begin
            first_half <= ~first_half;
            if (!first_half)
            begin
              state   <= ST_PUSH;
              bit_idx <= 4'h0;
            end
          end
        ST_PUSH:
          // Five data then three address bits, LSB first.
          if (slot_tick)
          begin
            first_half <= ~first_half;
            if (!first_half)
            begin
              shift_out <= {1'b0, shift_out[7:1]};
              if (bit_idx == 4'(swire_pkg::PUSH_BITS - 1))
                state <= ST_PSYNC;
              bit_idx <= bit_idx + 4'h1;
            end
          end
        ST_PSYNC:
          // Master issues the pull sync itself.
          if (slot_tick)
          begin
            first_half <= ~first_half;
            if (!first_half)
            begin
              state   <= ST_PULL;
              bit_idx <= 4'h0;
            end
          end
        ST_PULL:
          // One NRZ bit per slot.
          if (slot_tick)
          begin
            if (bit_idx == 4'(swire_pkg::PULL_BITS - 1))
              state <= ST_IDLE;
            bit_idx <= bit_idx + 4'h1;
          end
        ST_LONG:
          // Twenty low slots reset the slaves.
          if (slot_tick)
          begin
            if (slot_idx == 5'(swire_pkg::LONG_LOW_SLOTS - 1))
              state <= ST_IDLE;
            slot_idx <= slot_idx + 5'h01;
          end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Line drive
  // -----------------------------------------------------------------
  logic next_line; // Level for the push pin.

  // Level chosen per phase; idle leaves the line recessive.
  always_comb
  begin
    next_line = 1'b1;
    unique case (state)
      ST_IDLE:  next_line = 1'b1;
      ST_START: next_line = 1'b0;
      ST_SYNC:  next_line = biphase(1'b0, first_half);
      ST_PUSH:  next_line = biphase(shift_out[0], first_half);
      ST_PSYNC: next_line = biphase(1'b1, first_half);
      ST_PULL:  next_line = 1'b1;
      ST_LONG:  next_line = 1'b0;
    endcase
  end

  // Registered drive keeps the pin glitch free.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_push_out_pin <= 1'b1;
    else
      o_push_out_pin <= next_line;
  end

  // -----------------------------------------------------------------
  // Readback check and pull capture
  // -----------------------------------------------------------------
  logic push_phase; // Master owns the line.

  assign push_phase = (state == ST_START) | (state == ST_SYNC) |
                      (state == ST_PUSH);

  // Mid-slot compare of line against drive; cleared per frame.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      bit_error <= 1'b0;
    else if (state == ST_IDLE && i_push_valid && o_push_ready)
      bit_error <= 1'b0;
    else if (push_phase && mid_tick && (pin_sync != o_push_out_pin))
      bit_error <= 1'b1;
  end

  // Capture only in the pull phase with receive enabled.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      shift_in <= 8'h00;
    else if (state == ST_PSYNC)
      shift_in <= 8'h00;
    else if (state == ST_PULL && mid_tick && i_receive_enable)
      // First bit ends in bit 0 after eight shifts.
      shift_in <= {pin_sync, shift_in[7:1]};
  end

  // -----------------------------------------------------------------
  // Result buffer
  // -----------------------------------------------------------------
  logic frame_done; // Last pull slot ends.
  logic [swire_pkg::CODE_BITS-1:0] code; // Leading status bits.

  assign frame_done = (state == ST_PULL) && slot_tick &&
                      (bit_idx == 4'(swire_pkg::PULL_BITS - 1));
  assign code = shift_in[swire_pkg::CODE_BITS-1:0];

  // Finished pull byte is held for software.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      hold_full <= 1'b0;
      o_result  <= '0;
    end
    else if (frame_done)
    begin
      hold_full           <= 1'b1;
      o_result.pull_data  <= shift_in;
      o_result.bit_error  <= bit_error;
      // Status code all ones or all zeros marks a failed frame.
      o_result.code_bad   <= (&code) | ~(|code);
    end
    else if (i_result_ready)
      hold_full <= 1'b0;
  end

  assign o_result_valid = hold_full;

  // Busy flag registered for the pins.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_busy <= 1'b0;
    else
      o_busy <= (state != ST_IDLE);
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  sequence s_start_low;
    (state == ST_START) ##1 !o_push_out_pin;
  endsequence

  a_start_drives_low: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_START) |=> !o_push_out_pin)
    else $error("start slot not low");

  a_long_drives_low: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_LONG) |=> !o_push_out_pin)
    else $error("long low not low");

  a_idle_line_high: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_IDLE) |=> o_push_out_pin)
    else $error("idle line not recessive");

  a_sync_after_start: assert property (@(posedge i_clk) disable iff (i_rst)
    s_start_low ##0 ($past(state) == ST_START && state != ST_START)
      |-> state == ST_SYNC)
    else $error("start not followed by sync");

  a_push_to_psync: assert property (@(posedge i_clk) disable iff (i_rst)
    ($past(state) == ST_PUSH && state != ST_PUSH) |-> state == ST_PSYNC)
    else $error("push not followed by pull sync");

  a_no_capture_push: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_PUSH) |=> $stable(shift_in))
    else $error("capture during push");

  a_result_on_done: assert property (@(posedge i_clk) disable iff (i_rst)
    frame_done |=> o_result_valid && o_result.pull_data == $past(shift_in))
    else $error("pull byte not stored");

  a_error_sticky: assert property (@(posedge i_clk) disable iff (i_rst)
    (bit_error && state != ST_IDLE) |=> bit_error)
    else $error("bit error lost in frame");

endmodule

// [hw/swire_pkg.sv]
// Constants and carrier types for the single-wire push-pull master.
//
// Notes on behaviour
// - Master starts a frame whenever a byte arrives; the code waits for idle, a free result buffer and a slot boundary.
// - Three address bits select one of eight slaves.
// - Drive push pin; ignore pull pin during push.
// - Frame is push portion then pull portion.
// - Order: start, push sync, data, address.
// - Start is three low time slots.
// - Push sync is biphase zero.
// - Five data bits then three address bits.
// - Byte bits 4..0 data, 7..5 address.
// - Master sends pull sync as biphase one.
// - Pull bits NRZ, one sampled per slot.
// - Captured pull byte goes to frame data.
// - Biphase: zero high-low, one low-high.
// - Slot is half a push bit period.
// - Whole frame sequenced in hardware.
// - Pull code all ones or zeros invalid.
// - Readback mismatch in push sets bit error.
// - Long low request drives 20 low slots.
// - Receiver inhibited until pull sync issued.
package swire_pkg;

  // -----------------------------------------------------------------
  // Frame layout
  // -----------------------------------------------------------------
  localparam int START_SLOTS   = 3;   // Low slots of the start pattern.
  localparam int DATA_BITS     = 5;   // Push data bits.
  localparam int ADDR_BITS     = 3;   // Push address bits.
  localparam int PUSH_BITS     = 8;   // Data plus address.
  localparam int PULL_BITS     = 8;   // Pull bits captured per frame.
  localparam int LONG_LOW_SLOTS = 20; // Slots of a long low request.
  localparam int CODE_BITS     = 3;   // Width of the pull status code.

  // -----------------------------------------------------------------
  // Timing
  // -----------------------------------------------------------------
  localparam int CLK_HZ        = 10_000_000; // Core clock rate.
  localparam int PUSH_RATE_HZ  = 20_000;     // Typical push bit rate.
  localparam int SLOT_CYCLES   = CLK_HZ / (2 * PUSH_RATE_HZ);
  localparam logic [15:0] SLOT_DIV_RESET = 16'(SLOT_CYCLES);

  // -----------------------------------------------------------------
  // Carrier types
  // -----------------------------------------------------------------
  // The byte software hands in: address above data.
  typedef struct packed {
    logic [ADDR_BITS-1:0] addr;
    logic [DATA_BITS-1:0] data;
  } push_byte_t;

  // What the engine reports at the end of a frame.
  typedef struct packed {
    logic [PULL_BITS-1:0] pull_data;
    logic                 code_bad;
    logic                 bit_error;
  } frame_result_t;

endpackage

// [testbench/swire_slave_model.sv]
// Behavioural slave that answers addressed frames on the single wire.
`timescale 1ns/1ps
module swire_slave_model
#(
  parameter int SLOT = 8 // Core cycles per time slot.
)
(
  input  wire logic       i_clk,    // Core clock.
  input  wire logic       i_rst,    // Async reset.
  input  wire logic       i_wire,   // Resolved line level.
  input  wire logic [2:0] i_addr,   // Address this slave owns.
  input  wire logic [7:0] i_reply,  // Pull byte returned.
  input  wire logic       i_jam,    // Pull the sync slot low on purpose.
  output logic            o_drive_n // Low while pulling the line down.
);
  // -------------------------------------------------------------------
  // Frame tracking
  // -------------------------------------------------------------------
  int         cnt;    // Cycles since the frame's falling edge.
  logic       active; // A frame is in progress.
  logic [7:0] push;   // Push bits as read from the line.
  logic       hit;    // The frame names this slave.

  // The second slot of each biphase bit carries its value.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      active <= 1'b0;
      cnt    <= 0;
      push   <= 8'h00;
    end
    else if (!active)
    begin
      active <= !i_wire;
      cnt    <= 1;
    end
    else
    begin
      cnt    <= cnt + 1;
      active <= cnt < 34 * SLOT;
      for (int i = 0; i < 8; i++)
        if (cnt == (6 + 2 * i) * SLOT + SLOT / 2)
          push[i] <= i_wire;
    end
  end

  assign hit = (push[7:5] === i_addr);

  // Released slots fall back to the pull-up level, never a stale value.
  always_comb
  begin
    o_drive_n = 1'b1;
    if (active && i_jam && cnt >= 3 * SLOT && cnt < 4 * SLOT)
      o_drive_n = 1'b0;
    else if (active && hit && cnt >= 23 * SLOT && cnt < 31 * SLOT)
      o_drive_n = i_reply[cnt / SLOT - 23];
    else if (active && hit && cnt >= 31 * SLOT && cnt < 32 * SLOT)
      o_drive_n = 1'b0;
  end
endmodule

// [testbench/single_wire_push_pull_master_tb.sv]
// Self-checking bench for the single-wire push-pull master.
`timescale 1ns/1ps
module single_wire_push_pull_master_tb;
  // -------------------------------------------------------------------
  // Signals
  // -------------------------------------------------------------------
  localparam int SLOT = 8;          // Short slot keeps the run brief.
  logic                      clk;   // Core clock, 100 ns period.
  logic                      rst;   // Async reset.
  logic                      rx_en; // Pull capture enable.
  logic                      llow;  // Long low request.
  logic                      pvld;  // Byte offered.
  logic                      rrdy;  // Result taken.
  logic                      jam;   // Slave breaks the sync slot.
  logic                      drv_n; // Slave drive, low pulls down.
  logic                      line;  // Resolved wire with pull-up.
  logic                      prdy;  // Byte accepted.
  logic                      pin;   // Master line drive.
  logic                      rvld;  // Result held.
  logic                      busy;  // Frame running.
  logic [2:0]                saddr; // Slave's own address.
  logic [7:0]                reply; // Slave's pull byte.
  swire_pkg::push_byte_t     pbyte; // Byte to send.
  swire_pkg::frame_result_t  res;   // Frame result.
  int                        n_fail;
  int                        tests_run;

  assign line = pin & drv_n;

  swire_master DUT (.i_clk(clk), .i_rst(rst), .i_slot_div(16'h0008),
    .i_receive_enable(rx_en), .i_long_low_request(llow),
    .i_push_byte(pbyte), .i_push_valid(pvld), .o_push_ready(prdy),
    .i_pull_in_pin(line), .o_push_out_pin(pin), .o_result(res),
    .o_result_valid(rvld), .i_result_ready(rrdy), .o_busy(busy));

  swire_slave_model #(.SLOT(SLOT)) slave (.i_clk(clk), .i_rst(rst),
    .i_wire(line), .i_addr(saddr), .i_reply(reply), .i_jam(jam),
    .o_drive_n(drv_n));

  always #50 clk = ~clk;

  // -------------------------------------------------------------------
  // Comparison and closing tasks
  // -------------------------------------------------------------------
  task automatic chk_bit(input string what, input logic e, input logic g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic chk_byte(input string what, input logic [7:0] e,
                          input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Expected master drive in mid-slot j of a frame carrying byte b.
  function automatic logic pin_exp(input logic [7:0] b, input int j);
    if (j < 3)
      return 1'b0;
    if (j == 3)
      return 1'b1;
    if (j == 4)
      return 1'b0;
    if (j < 21)
      return ((j - 5) % 2 == 0) ? !b[(j - 5) / 2] : b[(j - 5) / 2];
    return j != 21;
  endfunction

  // Waits, bounded, until the master pulls its pin low.
  task automatic wait_fall();
    int k;
    k = 0;
    do
    begin
      @(posedge clk);
      #1;
      k++;
    end
    while (pin !== 1'b0 && k < 40 * SLOT);
    chk_bit("frame start", 1'b0, pin);
  endtask

  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  // One frame: the master's pin is judged slot by slot, then the result.
  task automatic run_frame(input logic [2:0] a, input logic [4:0] d,
    input logic [2:0] sa, input logic [7:0] rp, input logic rx,
    input logic jm, input logic [7:0] ep, input logic ee);
    int k;
    @(posedge clk);
    pbyte <= {a, d};
    pvld  <= 1'b1;
    saddr <= sa;
    reply <= rp;
    rx_en <= rx;
    jam   <= jm;
    wait_fall();
    @(posedge clk);
    pvld <= 1'b0;
    repeat (SLOT / 2 - 1) @(posedge clk);
    #1;
    for (int j = 0; j < 31; j++)
    begin
      chk_bit("push pin", pin_exp({a, d}, j), pin);
      if (j == 12)
      begin
        chk_bit("ready in frame", 1'b0, prdy);
        chk_bit("busy in frame", 1'b1, busy);
      end
      repeat (SLOT) @(posedge clk);
      #1;
    end
    k = 0;
    while (rvld !== 1'b1 && k < 4 * SLOT)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    chk_bit("result valid", 1'b1, rvld);
    chk_byte("pull data", ep, res.pull_data);
    chk_bit("code bad", ep[2:0] == 3'h0 || ep[2:0] == 3'h7,
            res.code_bad);
    chk_bit("bit error", ee, res.bit_error);
    @(posedge clk);
    rrdy <= 1'b1;
    @(posedge clk);
    rrdy <= 1'b0;
    #1;
    chk_bit("result cleared", 1'b0, rvld);
    repeat (4 * SLOT) @(posedge clk);
  endtask

  // A long low request holds the line down for 20 slots.
  task automatic long_low_test();
    int n;
    @(posedge clk);
    saddr <= 3'h7;
    llow  <= 1'b1;
    @(posedge clk);
    llow <= 1'b0;
    wait_fall();
    n = 0;
    while (pin === 1'b0 && n < 40 * SLOT)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_byte("long low slots", 8'(20), 8'(n / SLOT));
    chk_byte("long low cycles", 8'(20 * SLOT % 256), 8'(n));
    repeat (16 * SLOT) @(posedge clk);
  endtask

  // -------------------------------------------------------------------
  // Main sequence and watchdog
  // -------------------------------------------------------------------
  initial
  begin
    clk       = 1'b0;
    rst       = 1'b1;
    rx_en     = 1'b1;
    llow      = 1'b0;
    pvld      = 1'b0;
    rrdy      = 1'b0;
    jam       = 1'b0;
    saddr     = 3'h0;
    reply     = 8'hFF;
    pbyte     = '0;
    n_fail    = 0;
    tests_run = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    run_frame(3'h5, 5'h13, 3'h5, 8'hA6, 1'b1, 1'b0, 8'hA6, 1'b0);
    for (int a = 0; a < 8; a++)
      run_frame(3'(a), 5'(a * 3 + 1), 3'(a), 8'(8'h30 + a), 1'b1, 1'b0,
                8'(8'h30 + a), 1'b0);
    run_frame(3'h2, 5'h0A, 3'h4, 8'h5C, 1'b1, 1'b0, 8'hFF, 1'b0);
    run_frame(3'h1, 5'h15, 3'h1, 8'h5C, 1'b0, 1'b0, 8'h00, 1'b0);
    run_frame(3'h6, 5'h07, 3'h6, 8'h9A, 1'b1, 1'b1, 8'h9A, 1'b1);
    long_low_test();
    run_frame(3'h3, 5'h1C, 3'h3, 8'h65, 1'b1, 1'b0, 8'h65, 1'b0);
    report_and_stop();
  end

  // Thirteen frames and one long low of about 300 cycles each fit well inside this span.
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("[ERR] watchdog expected finish seen timeout");
    report_and_stop();
  end
endmodule
